/* core/pag_pkg.sv */
/*
 * pag_pkg: register map, constants and types of the port access block.
 * assumes one 100 MHz clock and 8-bit AXI4-Lite byte addresses.
 */
package pag_pkg;
  localparam int NUM_PORTS = 4;
  localparam int CLK_HZ = 100_000_000;
  localparam int TICK_PERIOD_S = 1;
  localparam int TICK_CYCLES = TICK_PERIOD_S * CLK_HZ;

  // global register byte addresses
  localparam logic [7:0] OFS_GLOBAL = 8'h00;
  localparam logic [7:0] OFS_FB_VLAN = 8'h04;
  localparam logic [7:0] OFS_MAX_REQ = 8'h08;
  localparam logic [7:0] OFS_IDENT_INTERVAL = 8'h0C;
  // per-port blocks: base + port * 16, four words each
  localparam logic [1:0] PORT_AREA = 2'h1;
  localparam logic [1:0] PR_CTRL = 2'h0;
  localparam logic [1:0] PR_REAUTH = 2'h1;
  localparam logic [1:0] PR_TIMERS = 2'h2;
  localparam logic [1:0] PR_STATUS = 2'h3;

  // field positions
  localparam int GB_ACCESS_EN = 0;
  localparam int GB_FB_GLOBAL_EN = 1;
  localparam int GB_DESPITE = 2;
  localparam int PC_MODE_LSB = 0;
  localparam int PC_REAUTH_EN = 2;
  localparam int PC_FB_PORT_EN = 3;
  localparam int TM_QUIET_LSB = 0;
  localparam int TM_SUPP_LSB = 16;
  localparam int ST_CNT_LSB = 8;

  // values after reset
  localparam logic [2:0] RST_GLOBAL = 3'h0;
  localparam logic [11:0] RST_FB_VLAN = 12'h001;
  localparam logic [7:0] RST_MAX_REQ = 8'h02;
  localparam logic [15:0] RST_IDENT_INTERVAL = 16'h001E;
  localparam logic [15:0] RST_REAUTH = 16'h0E10;
  localparam logic [15:0] RST_QUIET = 16'h003C;
  localparam logic [15:0] RST_SUPP = 16'h001E;
  localparam logic [3:0] RST_PORT_CTRL = 4'h4;

  // limits
  localparam logic [15:0] REAUTH_MIN = 16'h001E;
  localparam logic [11:0] FB_VLAN_MIN = 12'h001;
  localparam logic [11:0] FB_VLAN_MAX = 12'hFFE;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    MODE_NONE = 2'b00,
    MODE_AUTH = 2'b01,
    MODE_FORCE_OPEN = 2'b10,
    MODE_FORCE_CLOSED = 2'b11
  } pag_mode_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_OPEN = 3'b001,
    ST_REQ = 3'b010,
    ST_AUTHING = 3'b011,
    ST_AUTHED = 3'b100,
    ST_QUIET = 3'b101,
    ST_FALLBACK = 3'b110,
    ST_CLOSED = 3'b111
  } pag_state_t;
endpackage

/* core/pag_port_access.sv */
/*
 * pag_port_access: per-port access control engines and their AXI4-Lite register slave.
 * assumes link_up_pin is asynchronous and all frame events are one-cycle aclk pulses.
 */
// Register access over AXI4-Lite and the register offsets were left to the implementer.
// Functional notes
// - with control enabled each port runs none, auth, forced-open or forced-closed
// - forced-open sends one success frame at link up and grants access
// - forced-closed sends one failure frame at link up and denies access
// - reauth enabled: authenticated client redone when the period elapses
// - reauth period in seconds, 30 to 65535, used only when enabled
// - after authentication failure stay silent for the quiet period
// - identity request retransmitted while unanswered, at supplicant interval, or at identity interval on fallback-eligible ports
// - request count limit, writable only while fallback globally enabled
// - fallback port link up starts identity requests at identity interval
// - fallback considered only when count exceeds limit with no frame seen
// - despite-history enters at once, else only with history clear
// - history cleared on link down or administrative mode change
// - fallback port counts as authenticated, no success frame on entry
// - any frame in fallback leaves it and starts authentication
// - without despite-history a seen frame blocks reentry until cleared
// - fallback entry sets port vlan to number 1..4094, writable when enabled
// - global fallback enable gates per-port enables
// - fallback eligibility only in the authentication mode
// - control globally disabled: all ports forward freely
// - unauthorized port blocks traffic except authentication frames
// - link down or logoff returns port to unauthorized; logoff is ignored in fallback, none and forced-open
`timescale 1ns/1ps
module pag_port_access #(
  parameter int TICK_CYCLES = pag_pkg::TICK_CYCLES
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [pag_pkg::NUM_PORTS-1:0] link_up_pin,
  input wire logic [pag_pkg::NUM_PORTS-1:0] eapol_rx,
  input wire logic [pag_pkg::NUM_PORTS-1:0] eapol_logoff,
  input wire logic [pag_pkg::NUM_PORTS-1:0] auth_pass,
  input wire logic [pag_pkg::NUM_PORTS-1:0] auth_fail,
  output logic [pag_pkg::NUM_PORTS-1:0] tx_success_frame,
  output logic [pag_pkg::NUM_PORTS-1:0] tx_failure_frame,
  output logic [pag_pkg::NUM_PORTS-1:0] tx_identity_request,
  output logic [pag_pkg::NUM_PORTS-1:0] port_authorized,
  output logic [pag_pkg::NUM_PORTS-1:0] port_in_fallback,
  output logic [11:0] fallback_vlan_number
);
  localparam int NP = pag_pkg::NUM_PORTS;

  logic [2:0] global_q;
  logic [11:0] fb_vlan_q;
  logic [7:0] max_req_q;
  logic [15:0] ident_interval_q;
  logic [3:0] port_ctrl_q [NP];
  logic [15:0] reauth_period_q [NP];
  logic [15:0] quiet_q [NP];
  logic [15:0] supp_q [NP];
  pag_pkg::pag_state_t state_q [NP];
  logic [NP-1:0] hist_q;
  logic [7:0] req_cnt_q [NP];
  logic [NP-1:0] link_q;
  logic [NP-1:0] link_s1_q;
  logic [NP-1:0] link_s2_q;
  logic [NP-1:0] link_s3_q;

  logic access_en;
  logic fb_global_en;
  logic despite_en;
  assign access_en = global_q[pag_pkg::GB_ACCESS_EN];
  assign fb_global_en = global_q[pag_pkg::GB_FB_GLOBAL_EN];
  assign despite_en = global_q[pag_pkg::GB_DESPITE];
  assign fallback_vlan_number = fb_vlan_q;

  function automatic logic [31:0] merge_strb(input logic [31:0] old_v, input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] r;
    r = old_v;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = new_v[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // byte address names a register
  function automatic logic addr_mapped(input logic [7:0] a);
    return a[1:0] == 2'h0 && (a[7:4] == 4'h0 || a[7:6] == pag_pkg::PORT_AREA);
  endfunction

  logic [31:0] tick_cnt_q;
  logic tick_q;
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_cnt_q <= 32'h0;
      tick_q <= 1'b0;
    end else if (tick_cnt_q >= 32'(TICK_CYCLES - 1)) begin
      tick_cnt_q <= 32'h0;
      tick_q <= 1'b1;
    end else begin
      tick_cnt_q <= tick_cnt_q + 32'h1;
      tick_q <= 1'b0;
    end
  end

  // link pin: three flops, last two must agree
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      link_s1_q <= '0;
      link_s2_q <= '0;
      link_s3_q <= '0;
      link_q <= '0;
    end else begin
      link_s1_q <= link_up_pin;
      link_s2_q <= link_s1_q;
      link_s3_q <= link_s2_q;
      for (int p = 0; p < NP; p++) begin
        if (link_s2_q[p] == link_s3_q[p]) begin
          link_q[p] <= link_s3_q[p];
        end
      end
    end
  end

  // AXI4-Lite write channel
  logic aw_have_q;
  logic w_have_q;
  logic [7:0] aw_addr_q;
  logic [31:0] w_data_q;
  logic [3:0] w_strb_q;
  logic do_write;
  assign s_axi_awready = !aw_have_q && !s_axi_bvalid;
  assign s_axi_wready = !w_have_q && !s_axi_bvalid;
  assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      aw_addr_q <= 8'h00;
      w_data_q <= 32'h0;
      w_strb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= pag_pkg::RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_have_q <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_have_q <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= addr_mapped(aw_addr_q) ? pag_pkg::RESP_OKAY : pag_pkg::RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  // register writes
  logic [31:0] gw;
  logic [1:0] wport;
  logic wport_hit;
  assign wport = aw_addr_q[5:4];
  assign wport_hit = do_write && addr_mapped(aw_addr_q) && aw_addr_q[7:6] == pag_pkg::PORT_AREA;
  logic [31:0] pw;
  assign pw = merge_strb(aw_addr_q[3] ? {supp_q[wport], quiet_q[wport]} : aw_addr_q[2] ?
                         {16'h0, reauth_period_q[wport]} : {28'h0, port_ctrl_q[wport]},
                         w_data_q, w_strb_q);

  always_comb begin
    case (aw_addr_q)
      pag_pkg::OFS_GLOBAL: gw = merge_strb({29'h0, global_q}, w_data_q, w_strb_q);
      pag_pkg::OFS_FB_VLAN: gw = merge_strb({20'h0, fb_vlan_q}, w_data_q, w_strb_q);
      pag_pkg::OFS_MAX_REQ: gw = merge_strb({24'h0, max_req_q}, w_data_q, w_strb_q);
      pag_pkg::OFS_IDENT_INTERVAL: gw = merge_strb({16'h0, ident_interval_q}, w_data_q,
                                                   w_strb_q);
      default: gw = 32'h0;
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      global_q <= pag_pkg::RST_GLOBAL;
      fb_vlan_q <= pag_pkg::RST_FB_VLAN;
      max_req_q <= pag_pkg::RST_MAX_REQ;
      ident_interval_q <= pag_pkg::RST_IDENT_INTERVAL;
    end else if (do_write) begin
      case (aw_addr_q)
        pag_pkg::OFS_GLOBAL: global_q <= gw[2:0];
        // vlan number range and enable gate
        pag_pkg::OFS_FB_VLAN: begin
          if (fb_global_en && gw[11:0] >= pag_pkg::FB_VLAN_MIN &&
              gw[11:0] <= pag_pkg::FB_VLAN_MAX) begin
            fb_vlan_q <= gw[11:0];
          end
        end
        pag_pkg::OFS_MAX_REQ: begin
          if (fb_global_en) begin
            max_req_q <= gw[7:0];
          end
        end
        pag_pkg::OFS_IDENT_INTERVAL: ident_interval_q <= gw[15:0];
        default: ;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int p = 0; p < NP; p++) begin
        port_ctrl_q[p] <= pag_pkg::RST_PORT_CTRL;
        reauth_period_q[p] <= pag_pkg::RST_REAUTH;
        quiet_q[p] <= pag_pkg::RST_QUIET;
        supp_q[p] <= pag_pkg::RST_SUPP;
      end
    end else if (wport_hit) begin
      case (aw_addr_q[3:2])
        pag_pkg::PR_CTRL: port_ctrl_q[wport] <= pw[3:0];
        pag_pkg::PR_REAUTH: begin
          if (pw[15:0] >= pag_pkg::REAUTH_MIN) begin
            reauth_period_q[wport] <= pw[15:0];
          end
        end
        pag_pkg::PR_TIMERS: begin
          quiet_q[wport] <= pw[pag_pkg::TM_QUIET_LSB +: 16];
          supp_q[wport] <= pw[pag_pkg::TM_SUPP_LSB +: 16];
        end
        default: ;
      endcase
    end
  end

  // AXI4-Lite read channel
  logic [31:0] rmux;
  logic [1:0] rport;
  assign rport = s_axi_araddr[5:4];
  assign s_axi_arready = !s_axi_rvalid;

  always_comb begin
    if (s_axi_araddr[7:4] == 4'h0) begin
      case (s_axi_araddr)
        pag_pkg::OFS_GLOBAL: rmux = {29'h0, global_q};
        pag_pkg::OFS_FB_VLAN: rmux = {20'h0, fb_vlan_q};
        pag_pkg::OFS_MAX_REQ: rmux = {24'h0, max_req_q};
        pag_pkg::OFS_IDENT_INTERVAL: rmux = {16'h0, ident_interval_q};
        default: rmux = 32'h0;
      endcase
    end else begin
      case (s_axi_araddr[3:2])
        pag_pkg::PR_CTRL: rmux = {28'h0, port_ctrl_q[rport]};
        pag_pkg::PR_REAUTH: rmux = {16'h0, reauth_period_q[rport]};
        pag_pkg::PR_TIMERS: rmux = {supp_q[rport], quiet_q[rport]};
        pag_pkg::PR_STATUS: rmux = {16'h0, req_cnt_q[rport], link_q[rport],
                                    port_authorized[rport], hist_q[rport],
                                    port_in_fallback[rport], 1'b0, state_q[rport]};
        default: rmux = 32'h0;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= pag_pkg::RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= addr_mapped(s_axi_araddr) ? rmux : 32'h0;
      s_axi_rresp <= addr_mapped(s_axi_araddr) ? pag_pkg::RESP_OKAY : pag_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  for (genvar p = 0; p < NP; p++) begin : g_port
    pag_pkg::pag_mode_t mode;
    logic run;
    logic run_prev_q;
    logic [1:0] mode_prev_q;
    logic mode_changed;
    logic restart;
    logic eligible;
    logic [15:0] tmr_q;
    logic [15:0] reauth_q;
    logic tmr_exp;
    logic reauth_exp;
    logic [15:0] req_interval;

    assign mode = pag_pkg::pag_mode_t'(port_ctrl_q[p][pag_pkg::PC_MODE_LSB +: 2]);
    assign run = access_en && link_q[p];
    assign mode_changed = mode_prev_q != port_ctrl_q[p][pag_pkg::PC_MODE_LSB +: 2];
    assign restart = run && (!run_prev_q || mode_changed);
    assign eligible = fb_global_en && port_ctrl_q[p][pag_pkg::PC_FB_PORT_EN] &&
                      mode == pag_pkg::MODE_AUTH;
    assign tmr_exp = tick_q && tmr_q <= 16'h0001;
    assign reauth_exp = tick_q && reauth_q <= 16'h0001;
    assign req_interval = eligible ? ident_interval_q : supp_q[p];

    assign port_authorized[p] = !access_en || state_q[p] == pag_pkg::ST_OPEN ||
                                state_q[p] == pag_pkg::ST_AUTHED ||
                                state_q[p] == pag_pkg::ST_FALLBACK;
    assign port_in_fallback[p] = state_q[p] == pag_pkg::ST_FALLBACK;

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        hist_q[p] <= 1'b0;
      end else if (run && eapol_rx[p]) begin
        hist_q[p] <= 1'b1;
      end else if (!link_q[p] || mode_changed) begin
        hist_q[p] <= 1'b0;
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        state_q[p] <= pag_pkg::ST_IDLE;
        req_cnt_q[p] <= 8'h00;
        tmr_q <= 16'h0;
        reauth_q <= 16'h0;
        run_prev_q <= 1'b0;
        mode_prev_q <= pag_pkg::RST_PORT_CTRL[1:0];
        tx_success_frame[p] <= 1'b0;
        tx_failure_frame[p] <= 1'b0;
        tx_identity_request[p] <= 1'b0;
      end else begin
        run_prev_q <= run;
        mode_prev_q <= port_ctrl_q[p][pag_pkg::PC_MODE_LSB +: 2];
        tx_success_frame[p] <= 1'b0;
        tx_failure_frame[p] <= 1'b0;
        tx_identity_request[p] <= 1'b0;
        if (tick_q && tmr_q != 16'h0) begin
          tmr_q <= tmr_q - 16'h1;
        end
        if (tick_q && reauth_q != 16'h0) begin
          reauth_q <= reauth_q - 16'h1;
        end
        if (!run) begin
          state_q[p] <= pag_pkg::ST_IDLE;
          req_cnt_q[p] <= 8'h00;
        end else if (restart) begin
          case (mode)
            pag_pkg::MODE_FORCE_OPEN: begin
              state_q[p] <= pag_pkg::ST_OPEN;
              tx_success_frame[p] <= 1'b1;
            end
            pag_pkg::MODE_FORCE_CLOSED: begin
              state_q[p] <= pag_pkg::ST_CLOSED;
              tx_failure_frame[p] <= 1'b1;
            end
            pag_pkg::MODE_AUTH: begin
              state_q[p] <= pag_pkg::ST_REQ;
              tx_identity_request[p] <= 1'b1;
              req_cnt_q[p] <= 8'h01;
              tmr_q <= req_interval;
            end
            default: state_q[p] <= pag_pkg::ST_OPEN;
          endcase
        end else begin
          case (state_q[p])
            pag_pkg::ST_REQ: begin
              if (eapol_rx[p]) begin
                state_q[p] <= pag_pkg::ST_AUTHING;
                tmr_q <= supp_q[p];
              end else if (tmr_exp) begin
                if (eligible && req_cnt_q[p] > max_req_q && (despite_en || !hist_q[p])) begin
                  state_q[p] <= pag_pkg::ST_FALLBACK;
                end else begin
                  tx_identity_request[p] <= 1'b1;
                  tmr_q <= req_interval;
                  if (req_cnt_q[p] != 8'hFF) begin
                    req_cnt_q[p] <= req_cnt_q[p] + 8'h01;
                  end
                end
              end
            end
            pag_pkg::ST_AUTHING: begin
              if (auth_pass[p]) begin
                state_q[p] <= pag_pkg::ST_AUTHED;
                reauth_q <= reauth_period_q[p];
              end else if (auth_fail[p]) begin
                state_q[p] <= pag_pkg::ST_QUIET;
                tmr_q <= quiet_q[p];
              end else if (eapol_logoff[p] || tmr_exp) begin
                state_q[p] <= pag_pkg::ST_REQ;
                tx_identity_request[p] <= 1'b1;
                req_cnt_q[p] <= 8'h01;
                tmr_q <= req_interval;
              end
            end
            pag_pkg::ST_AUTHED: begin
              if (eapol_logoff[p]) begin
                state_q[p] <= pag_pkg::ST_REQ;
                tx_identity_request[p] <= 1'b1;
                req_cnt_q[p] <= 8'h01;
                tmr_q <= req_interval;
              end else if (port_ctrl_q[p][pag_pkg::PC_REAUTH_EN] && reauth_exp) begin
                state_q[p] <= pag_pkg::ST_AUTHING;
                tx_identity_request[p] <= 1'b1;
                tmr_q <= supp_q[p];
              end
            end
            pag_pkg::ST_QUIET: begin
              if (tmr_exp) begin
                state_q[p] <= pag_pkg::ST_REQ;
                tx_identity_request[p] <= 1'b1;
                req_cnt_q[p] <= 8'h01;
                tmr_q <= req_interval;
              end
            end
            pag_pkg::ST_FALLBACK: begin
              if (eapol_rx[p]) begin
                state_q[p] <= pag_pkg::ST_AUTHING;
                tx_identity_request[p] <= 1'b1;
                tmr_q <= supp_q[p];
              end
            end
            default: ;
          endcase
        end
      end
    end
  end
endmodule

/* verification/pag_chk.sv */
/* pag_chk: port-level and AXI4-Lite response assertions for the access control block.
   assumes it is bound onto pag_port_access; one clock, sync reset. */
`timescale 1ns/1ps
module pag_chk (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [1:0] s_axi_bresp,
  input wire logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [pag_pkg::NUM_PORTS-1:0] eapol_rx,
  input wire logic [pag_pkg::NUM_PORTS-1:0] tx_success_frame,
  input wire logic [pag_pkg::NUM_PORTS-1:0] tx_failure_frame,
  input wire logic [pag_pkg::NUM_PORTS-1:0] tx_identity_request,
  input wire logic [pag_pkg::NUM_PORTS-1:0] port_authorized,
  input wire logic [pag_pkg::NUM_PORTS-1:0] port_in_fallback,
  input wire logic [11:0] fallback_vlan_number
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  property p_open_grant; (tx_success_frame & ~port_authorized) == '0; endproperty
  a_open_grant: assert property (p_open_grant) else $error("success on closed port");
  property p_succ_once; |tx_success_frame |=> (tx_success_frame & $past(tx_success_frame)) == '0;
  endproperty
  a_succ_once: assert property (p_succ_once) else $error("success pulse too long");
  property p_closed_deny; (tx_failure_frame & port_authorized) == '0; endproperty
  a_closed_deny: assert property (p_closed_deny) else $error("failure on open port");
  property p_fb_auth; (port_in_fallback & ~port_authorized) == '0; endproperty
  a_fb_auth: assert property (p_fb_auth) else $error("fallback port not authorized");
  property p_fb_no_succ; (port_in_fallback & ~$past(port_in_fallback) & tx_success_frame) == '0;
  endproperty
  a_fb_no_succ: assert property (p_fb_no_succ) else $error("success on fallback entry");
  property p_fb_exit; |(port_in_fallback & eapol_rx) |=> (port_in_fallback
    & $past(port_in_fallback & eapol_rx)) == '0 && (tx_identity_request
    & $past(port_in_fallback & eapol_rx)) == $past(port_in_fallback & eapol_rx); endproperty
  a_fb_exit: assert property (p_fb_exit) else $error("fallback not left on frame");
  property p_vlan; |port_in_fallback |-> fallback_vlan_number inside {[12'h001:12'hFFE]};
  endproperty
  a_vlan: assert property (p_vlan) else $error("fallback vlan out of range");
  property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
  endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rhold; s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata);
  endproperty
  a_rhold: assert property (p_rhold) else $error("read data dropped");
endmodule
bind pag_port_access pag_chk u_chk (.aclk, .aresetn, .s_axi_bvalid, .s_axi_bready,
  .s_axi_bresp, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .eapol_rx, .tx_success_frame,
  .tx_failure_frame, .tx_identity_request, .port_authorized, .port_in_fallback,
  .fallback_vlan_number);

/* verification/pag_supplicant.sv */
/* pag_supplicant: attached clients that answer identity requests or start on a kick.
   assumes request pulses on aclk; answer picks the ports that respond. */
`timescale 1ns/1ps
module pag_supplicant (
  input wire logic aclk,
  input wire logic [3:0] tx_identity_request,
  input wire logic [3:0] answer,
  input wire logic [3:0] kick,
  input wire logic slow,
  output logic [3:0] eapol_rx
);
  logic [3:0] d1_q = 4'h0;
  logic [3:0] d2_q = 4'h0;
  always @(posedge aclk) begin
    d1_q <= tx_identity_request & answer;
    d2_q <= d1_q;
    eapol_rx <= (slow ? d2_q : d1_q) | kick;
  end
endmodule

/* verification/test_pag_port_access.sv */
/* test_pag_port_access: register model and port scenarios for the access block.
   assumes a short tick parameter and the partner clients in pag_supplicant. */
`timescale 1ns/1ps
module test_pag_port_access;
  logic aclk = 1'b0, aresetn = 1'b0, s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0;
  logic s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, slow = 1'b1;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hF, link_up_pin = 4'h0, eapol_logoff = 4'h0, auth_pass = 4'h0;
  logic [3:0] auth_fail = 4'h0, kick = 4'h0, answer = 4'h8, eapol_rx, tx_success_frame;
  logic [3:0] tx_failure_frame, tx_identity_request, port_authorized, port_in_fallback;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [11:0] fallback_vlan_number;
  logic [31:0] m[logic [7:0]];
  int errors = 0, cmp_count = 0, seed = 32'h3871, succ_n[4], fail_n[4], id_n[4], i;
  int rv[4] = '{29, 30, 65535, 29};
  always #5 aclk = ~aclk;
  pag_port_access #(.TICK_CYCLES(20)) u_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .link_up_pin, .eapol_rx,
    .eapol_logoff, .auth_pass, .auth_fail, .tx_success_frame, .tx_failure_frame,
    .tx_identity_request, .port_authorized, .port_in_fallback, .fallback_vlan_number);
  pag_supplicant u_sup (.aclk, .tx_identity_request, .answer, .kick, .slow, .eapol_rx);
  always @(posedge aclk) for (int p = 0; p < 4; p++) begin
    succ_n[p] += (tx_success_frame[p] === 1'b1);
    fail_n[p] += (tx_failure_frame[p] === 1'b1);
    id_n[p] += (tx_identity_request[p] === 1'b1);
  end
  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic ad, wd;
    ad = 1'b0;
    wd = 1'b0;
    s_axi_awaddr <= a; s_axi_wdata <= d; s_axi_awvalid <= 1'b1; s_axi_wvalid <= 1'b1;
    while (!(ad && wd)) begin
      @(posedge aclk);
      if (!ad && s_axi_awready === 1'b1) begin ad = 1'b1; s_axi_awvalid <= 1'b0; end
      if (!wd && s_axi_wready === 1'b1) begin wd = 1'b1; s_axi_wvalid <= 1'b0; end
    end
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    repeat ({$random(seed)} % 3) @(posedge aclk);
    s_axi_bready <= 1'b1;
    @(posedge aclk);
    s_axi_bready <= 1'b0;
    chk($sformatf("bresp %h", a), s_axi_bresp, m.exists(a) ? 2'h0 : 2'h2);
    if (a == 8'h00) m[a] = d & 32'h7;
    else if (a == 8'h04) begin
      if (m[8'h00][1] && d[11:0] >= 12'h001 && d[11:0] <= 12'hFFE) m[a] = d & 32'hFFF;
    end else if (a == 8'h08) begin
      if (m[8'h00][1]) m[a] = d & 32'hFF;
    end else if (a == 8'h0C) m[a] = d & 32'hFFFF;
    else if (m.exists(a)) case (a[3:2])
      2'h0: m[a] = d & 32'hF;
      2'h1: if (d[15:0] >= 16'h001E) m[a] = d & 32'hFFFF;
      default: m[a] = d;
    endcase
  endtask
  task automatic rd(input logic [7:0] a);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    repeat ({$random(seed)} % 3) @(posedge aclk);
    s_axi_rready <= 1'b1;
    @(posedge aclk);
    s_axi_rready <= 1'b0;
    chk($sformatf("rdata %h", a), s_axi_rdata, m.exists(a) ? m[a] : 32'h0);
    chk($sformatf("rresp %h", a), s_axi_rresp, m.exists(a) ? 2'h0 : 2'h2);
  endtask
  task automatic wait_fb(input int n);
    for (int k = 0; k < n && port_in_fallback[2] !== 1'b1; k++) @(posedge aclk);
  endtask
  initial begin
    repeat (30000) @(posedge aclk);
    errors++;
    test_done;
  end
  initial begin
    m[8'h00] = 32'h0; m[8'h04] = 32'h1; m[8'h08] = 32'h2; m[8'h0C] = 32'h1E;
    for (i = 0; i < 4; i++) begin
      m[8'h40 | 8'(i << 4)] = 32'h4;
      m[8'h44 | 8'(i << 4)] = 32'hE10;
      m[8'h48 | 8'(i << 4)] = 32'h001E003C;
    end
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    foreach (m[k]) rd(k);
    rd(8'h20);
    for (i = 0; i < 4; i++) begin wr(8'h44, rv[i]); rd(8'h44); end
    $display("test registers done");
    wr(8'h04, 1 + {$random(seed)} % 4094); rd(8'h04);
    wr(8'h08, 32'h5); rd(8'h08);
    wr(8'h00, 32'h3);
    for (i = 0; i < 3; i++) begin
      wr(8'h04, i == 0 ? 0 : i == 1 ? 32'hFFF : 1 + {$random(seed)} % 4094);
      rd(8'h04);
    end
    wr(8'h08, 32'h1); rd(8'h08);
    $display("test gated settings done");
    wr(8'h0C, 32'h2); wr(8'h40, 32'h2); wr(8'h50, 32'h3); wr(8'h60, 32'h9);
    wr(8'h68, 32'h00030005); wr(8'h70, 32'h1);
    link_up_pin <= 4'hF;
    repeat (30) @(posedge aclk);
    chk("success count", succ_n[0], 1);
    chk("failure count", fail_n[1], 1);
    chk("authorized", port_authorized, 4'h1);
    auth_pass <= 4'h8; @(posedge aclk); auth_pass <= 4'h0; repeat (2) @(posedge aclk);
    chk("authorized 3", port_authorized[3], 1);
    eapol_logoff <= 4'h8; @(posedge aclk); eapol_logoff <= 4'h0; repeat (2) @(posedge aclk);
    chk("logoff 3", port_authorized[3], 0);
    $display("test modes done");
    wait_fb(2000);
    chk("fallback", port_in_fallback[2], 1);
    chk("vlan", fallback_vlan_number, m[8'h04]);
    chk("fallback open", port_authorized[2], 1);
    chk("success 2", succ_n[2], 0);
    chk("requests", id_n[2] > int'(m[8'h08]), 1);
    kick <= 4'h4; @(posedge aclk); kick <= 4'h0; repeat (4) @(posedge aclk);
    chk("fallback exit", port_in_fallback[2], 0);
    repeat (400) @(posedge aclk);
    chk("no reentry", port_in_fallback[2], 0);
    wr(8'h00, 32'h7);
    wait_fb(1000);
    chk("despite entry", port_in_fallback[2], 1);
    wr(8'h00, 32'h3);
    link_up_pin <= 4'hB; repeat (10) @(posedge aclk); link_up_pin <= 4'hF;
    wait_fb(1000);
    chk("history cleared", port_in_fallback[2], 1);
    $display("test fallback done");
    wr(8'h00, 32'h0); repeat (3) @(posedge aclk);
    chk("disabled open", port_authorized, 4'hF);
    $display("test disable done");
    test_done;
  end
endmodule
